/* File: core/clk_fail_consts.vh */
`ifndef CLK_FAIL_CONSTS_VH
`define CLK_FAIL_CONSTS_VH

// primary clock failure threshold: nominal 1 kHz, one 1 ms period of 10 ns system clocks
`define PRI_FAIL_CYCLES      17'h186A0
`define PRI_CNT_W            17
// watchdog oscillator failure after this many system clocks without an edge
`define WDT_FAIL_CYCLES      13'h1F44
// last count of the watchdog quiet time before the trip
`define WDT_FAIL_LAST        13'h1F43
`define WDT_CNT_W            13

`endif

/* File: core/clock_failure_detect_recovery.v */
// What this block does
// - A detected primary oscillator failure raises a non-maskable style event toward the processor.
// - A detected primary oscillator failure moves the system clock over to the watchdog oscillator.
// - The move happens only if the watchdog oscillator is enabled, whatever the watchdog reset setting.
// - The primary clock is declared failed when its rate falls below the nominal 1 kHz threshold.
// - A detected watchdog oscillator failure raises a similar event and never switches the clock.
// - After a watchdog oscillator failure no primary oscillator failure is detected or reported.
// - The watchdog detector declares failure after 8004 system clocks pass without a watchdog edge.
`timescale 1ns/1ps
`include "clk_fail_consts.vh"

module clock_failure_detect_recovery #(
    parameter [`PRI_CNT_W-1:0] PRI_FAIL_CYCLES = `PRI_FAIL_CYCLES
) (
    // clock and reset
    input  wire clk,
    input  wire arst_n,
    // oscillator control register bits
    input  wire primary_fail_detect_en,
    input  wire wdt_osc_fail_detect_en,
    input  wire wdt_osc_enable,
    input  wire osc_source_select_wr,
    // oscillators being watched, sampled on clk
    input  wire primary_osc_clk,
    input  wire wdt_osc_clk,
    // events and status
    output reg  primary_fail_event,
    output reg  wdt_fail_event,
    output reg  primary_failed,
    output reg  wdt_failed,
    output reg  sys_clk_on_wdt
);

    // one-hot clock source states
    localparam [1:0]            SRC_PRIMARY = 2'h1;
    localparam [1:0]            SRC_WDT     = 2'h2;
    // counter steps and the last count before a trip
    localparam [`PRI_CNT_W-1:0] PRI_ONE     = {{(`PRI_CNT_W-1){1'b0}}, 1'b1};
    localparam [`PRI_CNT_W-1:0] PRI_LAST    = PRI_FAIL_CYCLES - PRI_ONE;
    localparam [`WDT_CNT_W-1:0] WDT_ONE     = {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
    localparam [`WDT_CNT_W-1:0] WDT_LAST    = `WDT_FAIL_LAST;

    // reset release
    reg                         rst_meta;
    reg                         rst_sync_n;
    // oscillator sampling, bit 0 primary and bit 1 watchdog
    wire [1:0]                  osc_in;
    reg  [1:0]                  osc_prev;
    wire [1:0]                  osc_edge;
    // quiet time counters
    reg  [`PRI_CNT_W-1:0]       pri_cnt;
    reg  [`PRI_CNT_W-1:0]       next_pri_cnt;
    reg  [`WDT_CNT_W-1:0]       wdt_cnt;
    reg  [`WDT_CNT_W-1:0]       next_wdt_cnt;
    wire                        pri_at_limit;
    wire                        wdt_at_limit;
    // trip decisions
    wire                        pri_armed;
    wire                        wdt_armed;
    wire                        pri_trip;
    wire                        wdt_trip;
    // status and clock source
    reg                         next_primary_failed;
    reg                         next_wdt_failed;
    reg  [1:0]                  src_state;
    reg  [1:0]                  next_src_state;
    genvar                      k;

    // the rest of the block leaves reset two edges after arst_n rises
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    assign osc_in = {wdt_osc_clk, primary_osc_clk};

    // a rising edge is a low sample followed by a high one
    generate
        for (k = 0; k < 2; k = k + 1) begin : g_osc
            always @(posedge clk or negedge rst_sync_n) begin
                if (!rst_sync_n) begin
                    osc_prev[k] <= 1'b0;
                end else begin
                    osc_prev[k] <= osc_in[k];
                end
            end
            assign osc_edge[k] = osc_in[k] & ~osc_prev[k];
        end
    endgenerate

    assign pri_at_limit = (pri_cnt == PRI_LAST);
    assign wdt_at_limit = (wdt_cnt == WDT_LAST);
    // primary detection is dead once the watchdog oscillator has failed
    assign pri_armed    = primary_fail_detect_en & ~primary_failed & ~wdt_failed;
    assign wdt_armed    = wdt_osc_fail_detect_en & ~wdt_failed;
    assign pri_trip     = pri_armed & pri_at_limit;
    assign wdt_trip     = wdt_armed & wdt_at_limit;

    // primary quiet time: restarts on an edge, at the limit, and while disabled
    always @* begin
        next_pri_cnt = pri_cnt + PRI_ONE;
        if (!primary_fail_detect_en) begin
            next_pri_cnt = {`PRI_CNT_W{1'b0}};
        end else if (osc_edge[0]) begin
            next_pri_cnt = {`PRI_CNT_W{1'b0}};
        end else if (pri_at_limit) begin
            next_pri_cnt = {`PRI_CNT_W{1'b0}};
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pri_cnt <= {`PRI_CNT_W{1'b0}};
        end else begin
            pri_cnt <= next_pri_cnt;
        end
    end

    // watchdog quiet time, counted in system clocks
    always @* begin
        next_wdt_cnt = wdt_cnt + WDT_ONE;
        if (!wdt_osc_fail_detect_en) begin
            next_wdt_cnt = {`WDT_CNT_W{1'b0}};
        end else if (osc_edge[1]) begin
            next_wdt_cnt = {`WDT_CNT_W{1'b0}};
        end else if (wdt_at_limit) begin
            next_wdt_cnt = {`WDT_CNT_W{1'b0}};
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            wdt_cnt <= {`WDT_CNT_W{1'b0}};
        end else begin
            wdt_cnt <= next_wdt_cnt;
        end
    end

    // a new failure wins over a source select write in the same cycle
    always @* begin
        next_primary_failed = primary_failed;
        if (pri_trip) begin
            next_primary_failed = 1'b1;
        end else if (osc_source_select_wr) begin
            next_primary_failed = 1'b0;
        end
    end

    // only a reset clears a watchdog oscillator failure
    always @* begin
        next_wdt_failed = wdt_failed;
        if (wdt_trip) begin
            next_wdt_failed = 1'b1;
        end
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            primary_failed <= 1'b0;
            wdt_failed     <= 1'b0;
        end else begin
            primary_failed <= next_primary_failed;
            wdt_failed     <= next_wdt_failed;
        end
    end

    // events last one cycle
    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            primary_fail_event <= 1'b0;
            wdt_fail_event     <= 1'b0;
        end else begin
            primary_fail_event <= pri_trip;
            wdt_fail_event     <= wdt_trip;
        end
    end

    // a watchdog oscillator failure never moves the clock
    always @* begin
        next_src_state = src_state;
        case (src_state)
            SRC_PRIMARY: begin
                // no move unless the watchdog oscillator runs to take over
                if (pri_trip && wdt_osc_enable) begin
                    next_src_state = SRC_WDT;
                end
            end
            SRC_WDT: begin
                // software picks a source again with a select write
                if (osc_source_select_wr) begin
                    next_src_state = SRC_PRIMARY;
                end
            end
            default: begin
                next_src_state = SRC_PRIMARY;
            end
        endcase
    end

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            src_state <= SRC_PRIMARY;
        end else begin
            src_state <= next_src_state;
        end
    end

    // the source flag comes straight from a flip-flop
    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sys_clk_on_wdt <= 1'b0;
        end else begin
            sys_clk_on_wdt <= (next_src_state == SRC_WDT);
        end
    end

endmodule

/* File: test/clk_fail_checker.sv */
`timescale 1ns/1ps
module clk_fail_checker #(
    parameter [16:0] PRI_FAIL_CYCLES = 17'h186A0
) (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // control
    input wire primary_fail_detect_en,
    input wire wdt_osc_fail_detect_en,
    input wire wdt_osc_enable,
    input wire osc_source_select_wr,
    // oscillators
    input wire primary_osc_clk,
    input wire wdt_osc_clk,
    // events and status
    input wire primary_fail_event,
    input wire wdt_fail_event,
    input wire primary_failed,
    input wire wdt_failed,
    input wire sys_clk_on_wdt
);
    reg        pp, wp;
    reg [16:0] pq;
    reg [13:0] wq;
    // cycles since the last sampled rising edge of each oscillator, saturating
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pp <= 1'b0;
            wp <= 1'b0;
            pq <= 17'h00000;
            wq <= 14'h0000;
        end else begin
            pp <= primary_osc_clk;
            wp <= wdt_osc_clk;
            pq <= (!primary_fail_detect_en || (primary_osc_clk && !pp)) ? 17'h00000 :
                  pq + {16'h0000, (pq < PRI_FAIL_CYCLES + 17'h00009)};
            wq <= (!wdt_osc_fail_detect_en || (wdt_osc_clk && !wp)) ? 14'h0000 : wq + {13'h0000, (wq < 14'h1F48)};
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_pri_event_flag: assert property (primary_fail_event |-> primary_failed) else $error("event without flag");
    a_pri_switch: assert property (primary_fail_event |-> sys_clk_on_wdt == $past(wdt_osc_enable))
        else $error("switch-over wrong");
    a_select_clears: assert property (osc_source_select_wr |=> !sys_clk_on_wdt || primary_fail_event)
        else $error("select write left clock on wdt");
    a_pri_quiet_min: assert property (primary_fail_event |-> pq >= PRI_FAIL_CYCLES - 17'h00004)
        else $error("early trip");
    a_pri_quiet_max: assert property (pq == PRI_FAIL_CYCLES + 17'h00004 |-> primary_failed || wdt_failed)
        else $error("late trip");
    a_wdt_flag: assert property (wdt_fail_event |-> wdt_failed) else $error("wdt event without flag");
    a_wdt_no_switch: assert property (wdt_fail_event && !primary_fail_event |-> $stable(sys_clk_on_wdt))
        else $error("wdt event switched clock");
    a_wdt_blocks_pri: assert property (primary_fail_event |-> !$past(wdt_failed)) else $error("trip after wdt fail");
    a_wdt_quiet_min: assert property (wdt_fail_event |-> wq >= 14'h1F40) else $error("early wdt trip");
    a_wdt_quiet_max: assert property (wq == 14'h1F48 |-> wdt_failed) else $error("late wdt trip");
endmodule
bind clock_failure_detect_recovery clk_fail_checker #(.PRI_FAIL_CYCLES(PRI_FAIL_CYCLES)) clk_fail_checker_i (.*);

/* File: test/tb_clock_failure_detect_recovery.sv */
`timescale 1ns/1ps
module tb_clock_failure_detect_recovery;
    reg     clk = 0, arst_n = 0, pde = 1, wde = 1, woe = 1, sel = 0, pc = 0, wc = 0, prun = 1, wrun = 1;
    wire    pe, we, sw, pf, wf;
    integer n_errors = 0, n_tests = 0, seed = 32'h914bd994, i;
    reg [3:0] q[$];
    always #5 clk = ~clk;
    clock_failure_detect_recovery #(.PRI_FAIL_CYCLES(17'h00032)) clock_failure_detect_recovery_i (.clk(clk),
        .arst_n(arst_n), .primary_fail_detect_en(pde), .wdt_osc_fail_detect_en(wde), .wdt_osc_enable(woe),
        .osc_source_select_wr(sel), .primary_osc_clk(pc), .wdt_osc_clk(wc), .primary_fail_event(pe),
        .wdt_fail_event(we), .primary_failed(pf), .wdt_failed(wf), .sys_clk_on_wdt(sw));
    // a running primary never stays quiet near the threshold
    always @(posedge clk) begin
        pc <= prun && ($random(seed) % 2 != 0);
        wc <= wrun && ($random(seed) % 2 != 0);
    end
    // oldest expectation: {wdt event, clock on wdt, primary failed, wdt failed}
    always @(posedge clk) if (pe === 1'b1 || we === 1'b1) begin
        n_tests = n_tests + 1;
        if (q.size() == 0 || {we, sw, pf, wf} !== q[0]) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED event exp %b seen %b", q[0], {we, sw, pf, wf});
        end
        if (q.size() != 0) q.pop_front();
    end
    task close_out;
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task go(input p, input w, input o, input x, input [3:0] e);
        @(posedge clk);
        prun <= p;
        wrun <= w;
        woe <= o;
        wde <= o;
        if (x) q.push_back(e);
        for (i = 0; i < 9000 && q.size() > 0; i = i + 1) @(posedge clk);
        if (q.size() > 0) begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED pending exp 0 seen %0d", q.size());
            close_out;
        end
        repeat (100) @(posedge clk);
        pde <= 0;
        wde <= 0;
        prun <= 1;
        @(posedge clk);
        sel <= 1;
        @(posedge clk);
        sel <= 0;
        pde <= 1;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1;
        repeat (100) @(posedge clk);
        go(0, 1, 1, 1, 4'h6);
        go(0, 1, 0, 1, 4'h2);
        go(1, 0, 1, 1, 4'h9);
        go(0, 0, 1, 0, 4'h0);
        close_out;
    end
endmodule
